// ---- rtl/sqal_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef SQAL_REGS_SVH
`define SQAL_REGS_SVH
`define SQAL_LEVEL_W 12
`define SQAL_HEIGHT_W 16
`define SQAL_X_W 8
`define SQAL_SD_W 25
`define SQAL_ADDR_W 8
`define SQAL_DATA_W 32
`define SQAL_REG_CTRL 8'h00
`define SQAL_REG_GAIN 8'h04
`define SQAL_REG_SWPT 8'h08
`define SQAL_REG_FOV 8'h0C
`define SQAL_REG_STATUS 8'h10
`define SQAL_REG_HEIGHT 8'h14
`define SQAL_REG_STDEV 8'h18
`define SQAL_REG_IRQ_STAT 8'h1C
`define SQAL_REG_IRQ_MASK 8'h20
`define SQAL_CTRL_W 2
`define SQAL_CTRL_SER_EN 0
`define SQAL_CTRL_SER_NOOBJ 1
`define SQAL_FOV_L_LSB 0
`define SQAL_FOV_R_LSB 8
`define SQAL_IRQ_W 4
`define SQAL_IRQ_MEAS 0
`define SQAL_IRQ_QUAL 1
`define SQAL_IRQ_ALARM 2
`define SQAL_IRQ_SD 3
`define SQAL_RST_CTRL 2'h0
`define SQAL_RST_GAIN 12'h100
`define SQAL_RST_SWPT 16'h8000
`define SQAL_RST_FOV_L 8'h00
`define SQAL_RST_FOV_R 8'hFF
`define SQAL_RST_MASK 4'h0
`define SQAL_CLK_HZ 100000000
`define SQAL_CLK_NS 10
`define SQAL_BLINK_HZ 8
`define SQAL_BLINK_HALF_CYC (`SQAL_CLK_HZ / (2 * `SQAL_BLINK_HZ))
`define SQAL_HOLD_LOW_NS 5000
`define SQAL_HOLD_LOW_CYC ((`SQAL_HOLD_LOW_NS + `SQAL_CLK_NS - 1) / `SQAL_CLK_NS)
`endif

// ---- rtl/sqal_pkg.sv ----
// Types shared by the signal quality alarm logic.
`include "sqal_regs.svh"
package sqal_pkg;
  typedef enum logic [1:0] {
    SQAL_Q_VALID = 2'h0,
    SQAL_Q_LOW = 2'h1,
    SQAL_Q_NONE = 2'h2
  } sqal_qual_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MEAS = 4'h2,
    ST_EVAL = 4'h4,
    ST_HOLD = 4'h8
  } sqal_state_t;
  typedef enum logic [2:0] {
    SD_ACC = 3'h1,
    SD_VAR = 3'h2,
    SD_ROOT = 3'h4
  } sqal_sd_state_t;
  typedef struct packed {
    logic done;
    logic object;
    logic [`SQAL_LEVEL_W-1:0] level;
    logic [`SQAL_HEIGHT_W-1:0] height;
  } sqal_meas_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [`SQAL_X_W-1:0] x;
    logic [`SQAL_HEIGHT_W-1:0] height;
  } sqal_point_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SQAL_ADDR_W-1:0] addr;
    logic [`SQAL_DATA_W-1:0] wdata;
  } sqal_bus_req_t;
  typedef struct packed {
    logic valid;
    logic [`SQAL_ADDR_W-1:0] addr;
    logic [`SQAL_DATA_W-1:0] data;
  } sqal_nvm_t;
endpackage

// ---- rtl/sqal_sync.sv ----
// Three-stage synchroniser for a pin level.
`timescale 1ns/1ps
`default_nettype none
module sqal_sync
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Pin and synchronised level.
  input wire logic pin_in,
  output logic level_out
);
  logic meta_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // A change is taken only once stages two and three agree.
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      meta_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        level_ff <= s3_ff;
    end
  end

  assign level_out = level_ff;
endmodule
`default_nettype wire

// ---- rtl/sqal_stddev.sv ----
// Height dispersion over the profile points inside the field of view.
`timescale 1ns/1ps
`default_nettype none
`include "sqal_regs.svh"
module sqal_stddev
  import sqal_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Profile points and field of view.
  input wire sqal_point_t point_in,
  input wire logic [`SQAL_X_W-1:0] fov_left_in,
  input wire logic [`SQAL_X_W-1:0] fov_right_in,
  // Result: count times sigma.
  output logic [`SQAL_SD_W-1:0] sd_out,
  output logic done_out
);
  localparam int HW = `SQAL_HEIGHT_W;
  localparam int XW = `SQAL_X_W;
  localparam int SW = `SQAL_SD_W;
  localparam int VW = 2 * SW;
  localparam int CW = XW + 1;
  localparam int SUMW = HW + XW;
  localparam int SQW = 2 * HW + XW;
  sqal_sd_state_t st_ff;
  logic [CW-1:0] cnt_ff;
  logic [SUMW-1:0] sum_ff;
  logic [SQW-1:0] sumsq_ff;
  logic [VW-1:0] val_ff;
  // The remainder can reach twice the root, so it keeps one extra bit.
  logic [SW:0] rem_ff;
  logic [SW-1:0] root_ff;
  logic [4:0] it_ff;
  logic [SW-1:0] sd_ff;
  logic done_ff;

  // Every point of the configured field counts, none is sampled out.
  wire in_fov = point_in.valid && (point_in.x >= fov_left_in)
    && (point_in.x <= fov_right_in);
  wire take = (st_ff == SD_ACC) && in_fov;
  wire [CW-1:0] nxt_cnt = take ? cnt_ff + CW'(1) : cnt_ff;
  wire [SUMW-1:0] nxt_sum = take ? sum_ff + SUMW'(point_in.height) : sum_ff;
  wire [SQW-1:0] nxt_sumsq = take ? sumsq_ff
    + SQW'(point_in.height) * SQW'(point_in.height) : sumsq_ff;
  // n*n*variance = n*sum(h*h) - sum(h)^2, kept integer to avoid a divider.
  wire [VW-1:0] var_n2 = VW'(cnt_ff) * VW'(sumsq_ff)
    - VW'(sum_ff) * VW'(sum_ff);
  wire [SW+2:0] rem_sh = {rem_ff, val_ff[VW-1 -: 2]};
  wire [SW+2:0] trial = {1'b0, root_ff, 2'b01};
  wire fits = rem_sh >= trial;
  wire [SW+2:0] rem_nx = fits ? rem_sh - trial : rem_sh;
  wire [SW-1:0] root_nx = {root_ff[SW-2:0], fits};

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_ff <= SD_ACC;
      cnt_ff <= '0;
      sum_ff <= '0;
      sumsq_ff <= '0;
      val_ff <= '0;
      rem_ff <= '0;
      root_ff <= '0;
      it_ff <= '0;
      sd_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (st_ff)
        SD_ACC:
        begin
          cnt_ff <= nxt_cnt;
          sum_ff <= nxt_sum;
          sumsq_ff <= nxt_sumsq;
          if (point_in.valid && point_in.last)
            st_ff <= SD_VAR;
        end
        SD_VAR:
        begin
          val_ff <= var_n2;
          rem_ff <= '0;
          root_ff <= '0;
          it_ff <= '0;
          cnt_ff <= '0;
          sum_ff <= '0;
          sumsq_ff <= '0;
          st_ff <= SD_ROOT;
        end
        SD_ROOT:
        begin
          val_ff <= {val_ff[VW-3:0], 2'b00};
          rem_ff <= rem_nx[SW:0];
          root_ff <= root_nx;
          it_ff <= it_ff + 5'h1;
          if (it_ff == 5'(SW - 1))
          begin
            sd_ff <= root_nx;
            done_ff <= 1'b1;
            st_ff <= SD_ACC;
          end
        end
      endcase
    end
  end

  assign sd_out = sd_ff;
  assign done_out = done_ff;

  AST_SD_COUNT: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    take && !point_in.last |=> cnt_ff == $past(cnt_ff) + CW'(1))
    else $error("in-field point not counted");
  AST_SD_DONE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    st_ff == SD_VAR |-> ##26 done_out)
    else $error("deviation result late");
  COV_SD_DONE: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    done_out && sd_out != '0);
endmodule
`default_nettype wire

// ---- rtl/sqal_top.sv ----
// Signal quality alarm logic: measurement sequencing and output control.
`timescale 1ns/1ps
`default_nettype none
`include "sqal_regs.svh"
// Notes on behaviour
// - Signal level is compared with the gain threshold every measurement.
// - Level below threshold with an object blinks the red lamp; the alarm stays low.
// - Object but weak signal: lamp blinks 8 Hz, pin low, low-signal code.
// - No object: lamp steady on, alarm pin high, no-signal code.
// - Alarm has no adjustable settings; fires on no object only, not on weak gain.
// - Alarm pin is push-pull, asserted high.
// - No hysteresis; alarm state may change every measurement.
// - Serial mode disables the alarm, switch and analog outputs or drives them as for no object.
// - Without an object the last measurement with an object, weak or valid, stays on the outputs.
// - While outputs are frozen for lack of object, alarm pin stays high unless serial mode silences the outputs.
// - Each configuration change from software is written to non-volatile storage; reloads from the store are not.
// - Height deviation covers every profile point in the field of view.
// - New measurement only while hold input is low; started ones finish.
module sqal_top
  import sqal_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `SQAL_BLINK_HALF_CYC,
  parameter int unsigned HOLD_LOW_CYC = `SQAL_HOLD_LOW_CYC
)
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port.
  input wire sqal_bus_req_t reg_req_in,
  output logic [`SQAL_DATA_W-1:0] reg_rdata_out,
  // Measurement front end.
  output logic meas_start_out,
  input wire sqal_meas_t meas_in,
  input wire sqal_point_t point_in,
  // Hold pin from the controller.
  input wire logic hold_pin_in,
  // Configuration store.
  output sqal_nvm_t nvm_store_out,
  input wire sqal_nvm_t nvm_load_in,
  // Sensor outputs.
  output logic alarm_pin_out,
  output logic led_red_out,
  output logic switch_out,
  output logic [`SQAL_HEIGHT_W-1:0] analog_out,
  output sqal_qual_t quality_out,
  output logic irq_out
);
  localparam int BW = $clog2(BLINK_HALF_CYC + 1);
  localparam int HLW = $clog2(HOLD_LOW_CYC + 1);
  localparam int IW = `SQAL_IRQ_W;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sqal_state_t st_ff;
  sqal_state_t nxt_st;
  sqal_meas_t smp_ff;
  sqal_qual_t qual_ff;
  sqal_nvm_t nvm_ff;
  logic [`SQAL_CTRL_W-1:0] ctrl_ff;
  logic [`SQAL_LEVEL_W-1:0] gain_ff;
  logic [`SQAL_HEIGHT_W-1:0] swpt_ff;
  logic [`SQAL_X_W-1:0] fov_l_ff;
  logic [`SQAL_X_W-1:0] fov_r_ff;
  logic [IW-1:0] mask_ff;
  logic [IW-1:0] irq_stat_ff;
  logic [`SQAL_HEIGHT_W-1:0] height_ff;
  logic alarm_ff;
  logic switch_ff;
  logic [BW-1:0] blink_cnt_ff;
  logic blink_ff;
  logic [HLW-1:0] hold_cnt_ff;
  logic [HLW-1:0] nxt_hold_cnt;
  logic [`SQAL_DATA_W-1:0] rdata_ff;
  logic alarm_pin_ff;
  logic led_ff;
  logic switch_out_ff;
  logic [`SQAL_HEIGHT_W-1:0] analog_ff;
  logic hold_lvl;
  logic [`SQAL_SD_W-1:0] sd_val;
  logic sd_done;

  sqal_sync u_hold_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(hold_pin_in),
    .level_out(hold_lvl)
  );

  sqal_stddev u_stddev (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .point_in(point_in),
    .fov_left_in(fov_l_ff),
    .fov_right_in(fov_r_ff),
    .sd_out(sd_val),
    .done_out(sd_done)
  );

  // Configuration writes come from software or from the store at power-up.
  wire cfg_we = reg_req_in.wr | nvm_load_in.valid;
  wire [`SQAL_ADDR_W-1:0] cfg_addr = reg_req_in.wr ? reg_req_in.addr
    : nvm_load_in.addr;
  wire [`SQAL_DATA_W-1:0] cfg_data = reg_req_in.wr ? reg_req_in.wdata
    : nvm_load_in.data;
  wire we_ctrl = cfg_we && (cfg_addr == `SQAL_REG_CTRL);
  wire we_gain = cfg_we && (cfg_addr == `SQAL_REG_GAIN);
  wire we_swpt = cfg_we && (cfg_addr == `SQAL_REG_SWPT);
  wire we_fov = cfg_we && (cfg_addr == `SQAL_REG_FOV);
  wire we_mask = reg_req_in.wr && (reg_req_in.addr == `SQAL_REG_IRQ_MASK);
  wire cfg_hit = we_ctrl | we_gain | we_swpt | we_fov;
  wire rd_irq = reg_req_in.rd && (reg_req_in.addr == `SQAL_REG_IRQ_STAT);

  wire ser_en = ctrl_ff[`SQAL_CTRL_SER_EN];
  wire ser_noobj = ctrl_ff[`SQAL_CTRL_SER_NOOBJ];
  wire ser_off = ser_en && !ser_noobj;

  // The comparison is a plain threshold, tunable only through the gain register.
  wire gain_ok = smp_ff.level >= gain_ff;
  wire sqal_qual_t eval_qual = !smp_ff.object ? SQAL_Q_NONE
    : (gain_ok ? SQAL_Q_VALID : SQAL_Q_LOW);
  wire is_eval = st_ff == ST_EVAL;
  wire [IW-1:0] irq_ev;
  assign irq_ev[`SQAL_IRQ_MEAS] = is_eval;
  assign irq_ev[`SQAL_IRQ_QUAL] = is_eval && (eval_qual != qual_ff);
  assign irq_ev[`SQAL_IRQ_ALARM] = is_eval && !smp_ff.object && !alarm_ff;
  assign irq_ev[`SQAL_IRQ_SD] = sd_done;

  // Lamp: off when valid, blinking when weak, steady when nothing seen.
  wire nxt_led = (qual_ff == SQAL_Q_NONE) ? 1'b1
    : ((qual_ff == SQAL_Q_LOW) ? blink_ff : 1'b0);
  // Serial mode either silences the alarm, switch and analog outputs or mimics the no-object state.
  wire nxt_alarm_pin = ser_en ? ser_noobj : alarm_ff;
  wire [`SQAL_HEIGHT_W-1:0] nxt_analog = ser_off ? '0 : height_ff;
  wire nxt_switch = ser_off ? 1'b0 : switch_ff;
  wire blink_wrap = blink_cnt_ff == BW'(BLINK_HALF_CYC - 1);

  wire [`SQAL_DATA_W-1:0] status_word = {{(`SQAL_DATA_W - 5){1'b0}},
    led_ff, hold_lvl, alarm_ff, qual_ff};
  wire [`SQAL_DATA_W-1:0] rd_mux =
    (reg_req_in.addr == `SQAL_REG_CTRL) ? `SQAL_DATA_W'(ctrl_ff)
    : (reg_req_in.addr == `SQAL_REG_GAIN) ? `SQAL_DATA_W'(gain_ff)
    : (reg_req_in.addr == `SQAL_REG_SWPT) ? `SQAL_DATA_W'(swpt_ff)
    : (reg_req_in.addr == `SQAL_REG_FOV) ? `SQAL_DATA_W'({fov_r_ff, fov_l_ff})
    : (reg_req_in.addr == `SQAL_REG_STATUS) ? status_word
    : (reg_req_in.addr == `SQAL_REG_HEIGHT) ? `SQAL_DATA_W'(height_ff)
    : (reg_req_in.addr == `SQAL_REG_STDEV) ? `SQAL_DATA_W'(sd_val)
    : (reg_req_in.addr == `SQAL_REG_IRQ_STAT) ? `SQAL_DATA_W'(irq_stat_ff)
    : (reg_req_in.addr == `SQAL_REG_IRQ_MASK) ? `SQAL_DATA_W'(mask_ff)
    : '0;

  // Hold is sampled only before a new exposure; a running one finishes.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_hold_cnt = '0;
    unique case (st_ff)
      ST_IDLE:
        nxt_st = hold_lvl ? ST_HOLD : ST_MEAS;
      ST_MEAS:
        if (meas_in.done)
          nxt_st = ST_EVAL;
      ST_EVAL:
        nxt_st = ST_IDLE;
      ST_HOLD:
      begin
        // The pin must stay low for the minimum time before restarting.
        if (!hold_lvl)
          nxt_hold_cnt = hold_cnt_ff + HLW'(1);
        if (!hold_lvl && (hold_cnt_ff == HLW'(HOLD_LOW_CYC - 1)))
          nxt_st = ST_IDLE;
      end
    endcase
  end

  assign meas_start_out = (st_ff == ST_IDLE) && !hold_lvl;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      st_ff <= ST_IDLE;
      hold_cnt_ff <= '0;
      smp_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
      hold_cnt_ff <= nxt_hold_cnt;
      if ((st_ff == ST_MEAS) && meas_in.done)
        smp_ff <= meas_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff <= `SQAL_RST_CTRL;
      gain_ff <= `SQAL_RST_GAIN;
      swpt_ff <= `SQAL_RST_SWPT;
      fov_l_ff <= `SQAL_RST_FOV_L;
      fov_r_ff <= `SQAL_RST_FOV_R;
      mask_ff <= `SQAL_RST_MASK;
      nvm_ff <= '0;
    end
    else
    begin
      if (we_ctrl)
        ctrl_ff <= cfg_data[`SQAL_CTRL_W-1:0];
      if (we_gain)
        gain_ff <= cfg_data[`SQAL_LEVEL_W-1:0];
      if (we_swpt)
        swpt_ff <= cfg_data[`SQAL_HEIGHT_W-1:0];
      if (we_fov)
      begin
        fov_l_ff <= cfg_data[`SQAL_FOV_L_LSB +: `SQAL_X_W];
        fov_r_ff <= cfg_data[`SQAL_FOV_R_LSB +: `SQAL_X_W];
      end
      if (we_mask)
        mask_ff <= reg_req_in.wdata[IW-1:0];
      // Software changes are mirrored to the store; reloads are not echoed.
      nvm_ff.valid <= reg_req_in.wr && cfg_hit;
      nvm_ff.addr <= reg_req_in.addr;
      nvm_ff.data <= reg_req_in.wdata;
    end
  end

  // Outputs move only at evaluation; with no object the old value stays.
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      qual_ff <= SQAL_Q_NONE;
      alarm_ff <= 1'b1;
      height_ff <= '0;
      switch_ff <= 1'b0;
    end
    else if (is_eval)
    begin
      qual_ff <= eval_qual;
      alarm_ff <= !smp_ff.object;
      if (smp_ff.object)
      begin
        height_ff <= smp_ff.height;
        switch_ff <= smp_ff.height >= swpt_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
    end
    else
    begin
      blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + BW'(1);
      if (blink_wrap)
        blink_ff <= !blink_ff;
    end
  end

  // The status bit set by an event wins over the clear of a read.
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      irq_stat_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~{IW{rd_irq}}) | irq_ev;
      rdata_ff <= reg_req_in.rd ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      alarm_pin_ff <= 1'b0;
      led_ff <= 1'b0;
      switch_out_ff <= 1'b0;
      analog_ff <= '0;
    end
    else
    begin
      alarm_pin_ff <= nxt_alarm_pin;
      led_ff <= nxt_led;
      switch_out_ff <= nxt_switch;
      analog_ff <= nxt_analog;
    end
  end

  // Push-pull drive: the pin is always driven, high means alarm.
  assign alarm_pin_out = alarm_pin_ff;
  assign led_red_out = led_ff;
  assign switch_out = switch_out_ff;
  assign analog_out = analog_ff;
  assign quality_out = qual_ff;
  assign reg_rdata_out = rdata_ff;
  assign nvm_store_out = nvm_ff;
  assign irq_out = |(irq_stat_ff & mask_ff);

  AST_START_NO_HOLD: assert property (
    meas_start_out |-> !hold_lvl && st_ff == ST_IDLE ##1 st_ff == ST_MEAS)
    else $error("measurement started during hold");
  AST_EVAL_FOLLOWS: assert property (
    st_ff == ST_MEAS && meas_in.done |=> is_eval ##1 st_ff == ST_IDLE)
    else $error("measurement not evaluated");
  AST_WEAK_SIGNAL: assert property (
    is_eval && smp_ff.object && !gain_ok |=> qual_ff == SQAL_Q_LOW
      && !alarm_ff)
    else $error("weak signal reported wrongly");
  AST_NO_OBJECT: assert property (
    is_eval && !smp_ff.object |=> qual_ff == SQAL_Q_NONE && alarm_ff
      ##1 led_red_out)
    else $error("no-object state reported wrongly");
  AST_VALID: assert property (
    is_eval && smp_ff.object && gain_ok |=> qual_ff == SQAL_Q_VALID
      ##1 !led_red_out)
    else $error("valid state reported wrongly");
  AST_BLINK: assert property (
    qual_ff == SQAL_Q_LOW |=> led_red_out == $past(blink_ff))
    else $error("lamp not blinking on weak signal");
  AST_HOLD_LAST: assert property (
    is_eval && !smp_ff.object |=> $stable(height_ff) ##1 $past(ser_off)
      || analog_out == $past(height_ff))
    else $error("held value changed without object");
  AST_ALARM_FROZEN: assert property (
    !ser_en && qual_ff == SQAL_Q_NONE |=> alarm_pin_out)
    else $error("alarm pin low while no object");
  AST_SERIAL_OFF: assert property (
    ser_off |=> !alarm_pin_out && analog_out == '0 && !switch_out)
    else $error("outputs active in serial mode");
  AST_NVM_STORE: assert property (
    reg_req_in.wr && cfg_hit |=> nvm_store_out.valid
      && nvm_store_out.data == $past(reg_req_in.wdata))
    else $error("configuration change not stored");
  COV_WEAK: cover property (is_eval && smp_ff.object && !gain_ok);
  COV_NO_OBJ: cover property (is_eval && !smp_ff.object);
  COV_HOLD: cover property (st_ff == ST_HOLD ##1 st_ff == ST_IDLE);
  COV_SERIAL: cover property (ser_en && ser_noobj && alarm_pin_out);
endmodule
`default_nettype wire

// ---- sim/sqal_fe_model.sv ----
// Behavioural measurement front end that answers each start pulse.
`timescale 1ns/1ps
`default_nettype none
`include "sqal_regs.svh"
module sqal_fe_model
  import sqal_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Start request and the scene to report.
  input wire logic start_in,
  input wire logic object_in,
  input wire logic [`SQAL_LEVEL_W-1:0] level_in,
  input wire logic [`SQAL_HEIGHT_W-1:0] height_in,
  input wire logic [3:0] delay_in,
  // Result towards the block.
  output sqal_meas_t meas_out
);
  logic busy_ff;
  logic done_ff;
  logic [3:0] cnt_ff;
  // Outside the done cycle the fields carry the inverse, so stale data
  // can never pass for a fresh result.
  assign meas_out = done_ff ? {1'b1, object_in, level_in, height_in}
    : {1'b0, ~object_in, ~level_in, ~height_in};
  always_ff @(posedge clk_sys_in)
  begin
    done_ff <= 1'b0;
    if (sys_rst_in)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end
    else if (busy_ff)
    begin
      busy_ff <= (cnt_ff != 4'h0);
      done_ff <= (cnt_ff == 4'h0);
      cnt_ff <= cnt_ff - 4'h1;
    end
    else if (start_in)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= delay_in;
    end
  end
endmodule
`default_nettype wire

// ---- sim/signal_quality_alarm_logic_tb.sv ----
// Self-checking bench for the signal quality alarm logic.
`timescale 1ns/1ps
`default_nettype none
`include "sqal_regs.svh"
module signal_quality_alarm_logic_tb
  import sqal_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hold_pin_in = 1'b0;
  logic fe_object = 1'b0;
  logic [11:0] fe_level = 12'h000;
  logic [15:0] fe_height = 16'h0000;
  sqal_bus_req_t reg_req_in = '0;
  sqal_point_t point_in = '0;
  sqal_nvm_t nvm_load_in = '0;
  sqal_nvm_t nvm_store_out;
  sqal_nvm_t last_nvm;
  sqal_meas_t meas_in;
  sqal_qual_t quality_out;
  logic [31:0] reg_rdata_out;
  logic [31:0] rv;
  logic [15:0] analog_out;
  logic meas_start_out, alarm_pin_out, led_red_out, switch_out, irq_out;
  int n_fail = 0;
  int checked = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  // One sensor sits alone on the serial bus, well inside the limit.
  sqal_top #(.BLINK_HALF_CYC(4), .HOLD_LOW_CYC(3)) i_sqal_top (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .meas_start_out(meas_start_out), .meas_in(meas_in),
    .point_in(point_in), .hold_pin_in(hold_pin_in),
    .nvm_store_out(nvm_store_out), .nvm_load_in(nvm_load_in),
    .alarm_pin_out(alarm_pin_out), .led_red_out(led_red_out),
    .switch_out(switch_out), .analog_out(analog_out),
    .quality_out(quality_out), .irq_out(irq_out));
  sqal_fe_model i_sqal_fe_model (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .start_in(meas_start_out), .object_in(fe_object),
    .level_in(fe_level), .height_in(fe_height), .delay_in(4'h2),
    .meas_out(meas_in));
  task automatic chk(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_req_in <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys_in);
    reg_req_in <= '0;
    #1 last_nvm = nvm_store_out;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_req_in <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys_in);
    reg_req_in <= '0;
    #1 d = reg_rdata_out;
  endtask
  task automatic scene(input logic o, input logic [11:0] l,
                       input logic [15:0] h);
    @(posedge clk_sys_in);
    fe_object <= o;
    fe_level <= l;
    fe_height <= h;
    tick(24);
  endtask
  task automatic t_reset;
    chk("quality", 32'(SQAL_Q_NONE), 32'(quality_out));
    chk("alarm", 32'h1, 32'(alarm_pin_out));
    rd(`SQAL_REG_GAIN, rv);
    chk("gain", 32'h100, rv);
    rd(`SQAL_REG_FOV, rv);
    chk("fov", 32'hFF00, rv);
    rd(8'h40, rv);
    chk("unmapped", 32'h0, rv);
    rd(`SQAL_REG_STATUS, rv);
    chk("status", 32'h16, rv);
  endtask
  task automatic t_levels;
    int tg;
    logic prev;
    scene(1'b1, 12'h100, 16'h9000);
    chk("quality", 32'(SQAL_Q_VALID), 32'(quality_out));
    chk("alarm", 32'h0, 32'(alarm_pin_out));
    chk("led", 32'h0, 32'(led_red_out));
    chk("analog", 32'h9000, 32'(analog_out));
    chk("switch", 32'h1, 32'(switch_out));
    scene(1'b1, 12'h0FF, 16'h1234);
    chk("quality", 32'(SQAL_Q_LOW), 32'(quality_out));
    tg = 0;
    prev = led_red_out;
    repeat (16)
    begin
      tick(1);
      if (led_red_out !== prev)
        tg++;
      prev = led_red_out;
      chk("alarm", 32'h0, 32'(alarm_pin_out));
    end
    chk("toggles", 32'h4, 32'(tg));
    scene(1'b1, 12'h100, 16'hC321);
    chk("quality", 32'(SQAL_Q_VALID), 32'(quality_out));
    scene(1'b0, 12'hFFF, 16'h7777);
    chk("quality", 32'(SQAL_Q_NONE), 32'(quality_out));
    chk("led", 32'h1, 32'(led_red_out));
    chk("alarm", 32'h1, 32'(alarm_pin_out));
    chk("analog", 32'hC321, 32'(analog_out));
    chk("switch", 32'h1, 32'(switch_out));
  endtask
  task automatic t_serial;
    wr(`SQAL_REG_CTRL, 32'h1);
    tick(2);
    chk("alarm", 32'h0, 32'(alarm_pin_out));
    chk("analog", 32'h0, 32'(analog_out));
    chk("switch", 32'h0, 32'(switch_out));
    wr(`SQAL_REG_CTRL, 32'h3);
    tick(2);
    chk("alarm", 32'h1, 32'(alarm_pin_out));
    chk("analog", 32'hC321, 32'(analog_out));
    chk("switch", 32'h1, 32'(switch_out));
    wr(`SQAL_REG_CTRL, 32'h0);
  endtask
  task automatic t_store;
    wr(`SQAL_REG_GAIN, 32'h200);
    chk("store", 32'h200, 32'(last_nvm));
    chk("store_hi", 32'h0104, 32'(last_nvm >> 32));
    scene(1'b1, 12'h1FF, 16'h5000);
    chk("quality", 32'(SQAL_Q_LOW), 32'(quality_out));
  endtask
  task automatic t_hold;
    int n;
    wr(`SQAL_REG_IRQ_MASK, 32'h1);
    @(posedge clk_sys_in);
    hold_pin_in <= 1'b1;
    tick(16);
    rd(`SQAL_REG_IRQ_STAT, rv);
    chk("irq_stat", 32'h1, rv & 32'h1);
    tick(1);
    chk("irq", 32'h0, 32'(irq_out));
    n = 0;
    repeat (30)
    begin
      tick(1);
      if (meas_start_out === 1'b1)
        n++;
    end
    chk("starts", 32'h0, 32'(n));
    @(posedge clk_sys_in);
    hold_pin_in <= 1'b0;
    n = 0;
    while (meas_start_out !== 1'b1 && n < 30)
    begin
      tick(1);
      n++;
    end
    chk("restart", 32'h1, 32'(meas_start_out));
    tick(12);
    chk("irq", 32'h1, 32'(irq_out));
    wr(`SQAL_REG_IRQ_MASK, 32'h0);
    tick(1);
    chk("irq", 32'h0, 32'(irq_out));
  endtask
  task automatic t_stdev;
    logic [7:0] xs [4] = '{8'h01, 8'h02, 8'h06, 8'h05};
    logic [15:0] hs [4] = '{16'd100, 16'd10, 16'd50, 16'd14};
    wr(`SQAL_REG_FOV, 32'h0502);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_in);
      point_in <= {1'b1, (i == 3), xs[i], hs[i]};
    end
    @(posedge clk_sys_in);
    point_in <= '0;
    tick(40);
    rd(`SQAL_REG_STDEV, rv);
    chk("stdev", 32'h4, rv);
    rd(`SQAL_REG_IRQ_STAT, rv);
    chk("irq_sd", 32'h8, rv & 32'h8);
  endtask
  task automatic summarize;
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    tick(3);
    t_reset();
    t_levels();
    t_serial();
    t_store();
    t_hold();
    t_stdev();
    summarize();
  end
endmodule
`default_nettype wire
